// *** hw/cluster_defs.svh ***
// constants for the logic cluster and its control fabric
// Functional notes
// - ten cells share interconnect, controls and chains
// - 26 external inputs plus ten feedback lines
// - lut result passes directly to next cell
// - register output shifts into next cell register
// - ten cluster controls, at most ten active
// - each cluster clock has its own gate
// - both edges of one source use both clocks
// - gate low stops that cluster clock
// - default preset by inverting register data path
// - otherwise preset via async load of one
// - cluster add/subtract select, switchable by logic
// - controls from four column clocks plus local lines
// - four global lines carry clocks or controls
// - cell output reaches thirty cells via links
// - local lines fed by routing, cells, neighbours
`ifndef CLUSTER_DEFS_SVH
`define CLUSTER_DEFS_SVH
`define NUM_CELLS 10
`define NUM_EXT 26
`define NUM_FB 10
`define NUM_LOCAL 36
`define NUM_COL 4
`define NUM_ROUTE 24
`define NUM_NBR 10
`define NUM_POOL 44
`define NUM_CTLSRC 40
`define NUM_CTRL 10
`define SEL_W 6
`define LUT_W 16
`define CTL_CLK1 0
`define CTL_CLK2 1
`define CTL_GATE1 2
`define CTL_GATE2 3
`define CTL_ACLR1 4
`define CTL_ACLR2 5
`define CTL_SCLR 6
`define CTL_ALOAD 7
`define CTL_SLOAD 8
`define CTL_ADDSUB 9
`endif

// *** hw/cluster_pkg.sv ***
// types shared by the logic cluster and its cells
package cluster_pkg;
  typedef struct packed {
    logic [15:0] lut_mask;
    logic [3:0][5:0] data_sel;
    logic arith;
    logic use_lut_chain;
    logic use_reg_chain;
    logic clk_sel;
    logic aclr_sel;
    logic preset_by_aload;
    logic powerup_high;
  } cell_cfg_t;

  typedef struct packed {
    logic [25:0][5:0] line_sel;
    logic [9:0][5:0] ctl_sel;
    logic clk2_falling;
    logic both_edges;
  } cluster_cfg_t;

  typedef struct packed {
    logic tick1;
    logic tick2;
    logic aclr1;
    logic aclr2;
    logic sclr;
    logic aload;
    logic sload;
    logic addnsub;
  } cell_ctrl_t;

  typedef enum logic {
    ST_POWERUP = 1'b0,
    ST_RUN = 1'b1
  } init_state_t;
endpackage

// *** hw/logic_cell.sv ***
// one logic cell: four-input lut, arithmetic slice and register
`timescale 1ns/1ps
`include "cluster_defs.svh"
module logic_cell (
  input wire logic clk,
  input wire logic rst,
  input cluster_pkg::cell_cfg_t cfg,
  input cluster_pkg::cell_ctrl_t ctl,
  input wire logic init,
  input wire logic [3:0] data,
  input wire logic lut_chain_in,
  input wire logic reg_chain_in,
  input wire logic carry_in,
  output logic lut_out,
  output logic carry_out,
  output logic q
);
  logic [3:0] lut_in;
  logic lut_val;
  logic b_eff;
  logic sum;
  logic d_sel;
  logic tick;
  logic aclr;
  logic inv;
  logic stored_r;

  // chain input replaces data0 so no local line is spent on it
  assign lut_in = cfg.use_lut_chain ? {data[3:1], lut_chain_in} : data;
  assign lut_val = cfg.lut_mask[lut_in];
  assign b_eff = data[1] ^ ctl.addnsub;
  assign sum = data[0] ^ b_eff ^ carry_in;
  assign carry_out = (data[0] & b_eff) | (carry_in & (data[0] ^ b_eff));
  assign lut_out = cfg.arith ? sum : lut_val;
  assign d_sel = cfg.use_reg_chain ? reg_chain_in : lut_out;
  assign tick = cfg.clk_sel ? ctl.tick2 : ctl.tick1;
  assign aclr = cfg.aclr_sel ? ctl.aclr2 : ctl.aclr1;
  // inverted data path turns a clear into a preset
  assign inv = ~cfg.preset_by_aload;
  assign q = stored_r ^ inv;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stored_r <= 1'b0;
    end else if (init) begin
      stored_r <= cfg.powerup_high ^ inv;
    end else if (aclr) begin
      stored_r <= 1'b0;
    end else if (ctl.aload) begin
      stored_r <= (cfg.preset_by_aload | data[3]) ^ inv;
    end else if (tick) begin
      if (ctl.sclr) begin
        stored_r <= inv;
      end else if (ctl.sload) begin
        stored_r <= data[2] ^ inv;
      end else begin
        stored_r <= d_sel ^ inv;
      end
    end
  end
endmodule

// *** hw/logic_cluster.sv ***
// logic cluster: local routing, control generation and ten cells
`timescale 1ns/1ps
`include "cluster_defs.svh"
module logic_cluster (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] col_clk,
  input wire logic [23:0] route_in,
  input wire logic [9:0] left_in,
  input wire logic [9:0] right_in,
  input cluster_pkg::cluster_cfg_t cfg,
  input cluster_pkg::cell_cfg_t [9:0] cell_cfg,
  output logic [9:0] cell_out,
  output logic carry_out
);
  logic [`NUM_COL-1:0] col_meta_r;
  logic [`NUM_COL-1:0] col_s_r;
  logic [`NUM_ROUTE-1:0] route_meta_r;
  logic [`NUM_ROUTE-1:0] route_s_r;
  logic [`NUM_POOL-1:0] pool;
  logic [`NUM_EXT-1:0] ext_lines;
  logic [`NUM_LOCAL-1:0] local_bus;
  logic [`NUM_CTLSRC-1:0] ctl_pool;
  logic [`NUM_CTRL-1:0] ctl_raw;
  logic [`NUM_CELLS-1:0] q;
  logic [`NUM_CELLS-1:0] lut_out;
  logic [`NUM_CELLS-1:0] cout;
  logic [`NUM_CELLS-1:0] cin;
  logic [`NUM_CELLS-1:0] lut_chain;
  logic [`NUM_CELLS-1:0] reg_chain;
  logic src1;
  logic src2;
  logic src1_prev_r;
  logic src2_prev_r;
  logic gate1_hold_r;
  logic gate2_hold_r;
  logic edge1;
  logic edge2;
  logic idle2;
  logic idle1;
  logic falling2;
  logic init_now;
  cluster_pkg::cell_ctrl_t ctl;
  cluster_pkg::init_state_t st_r;
  cluster_pkg::init_state_t st_nxt;

  // a selector reaching past the pool reads zero, so unused slots stay quiet
  function automatic logic pick(input logic [63:0] bus, input logic [5:0] sel);
    pick = bus[sel];
  endfunction

  // edge of a synchronised line; falling picks the high-to-low edge
  function automatic logic edge_seen(input logic cur, input logic prev, input logic falling);
    edge_seen = falling ? (~cur & prev) : (cur & ~prev);
  endfunction

  // a clock idles low when counted on its rise and high when counted on its fall
  function automatic logic clock_idle(input logic cur, input logic falling);
    clock_idle = falling ? cur : ~cur;
  endfunction

  // pins and global lines are asynchronous to clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      col_meta_r <= 4'h0;
      col_s_r <= 4'h0;
    end else begin
      col_meta_r <= col_clk;
      col_s_r <= col_meta_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      route_meta_r <= 24'h000000;
      route_s_r <= 24'h000000;
    end else begin
      route_meta_r <= route_in;
      route_s_r <= route_meta_r;
    end
  end

  // row/column routing plus both neighbour clusters feed the line selectors
  assign pool = {right_in, left_in, route_s_r};

  always_comb begin
    for (int k = 0; k < `NUM_EXT; k++) begin
      ext_lines[k] = pick({20'h00000, pool}, cfg.line_sel[k]);
    end
  end

  // 26 selected lines plus one feedback line per cell
  assign local_bus = {q, ext_lines};
  // global column lines may carry clocks, clears or any control
  assign ctl_pool = {local_bus, col_s_r};

  // exactly ten control slots, so never more than ten in use
  always_comb begin
    for (int k = 0; k < `NUM_CTRL; k++) begin
      ctl_raw[k] = pick({24'h000000, ctl_pool}, cfg.ctl_sel[k]);
    end
  end

  // both-edge use takes clock two onto the clock one source
  assign src1 = ctl_raw[`CTL_CLK1];
  assign src2 = cfg.both_edges ? ctl_raw[`CTL_CLK1] : ctl_raw[`CTL_CLK2];
  // clock two counts falls when asked, or as the other half of clock one
  assign falling2 = cfg.clk2_falling | cfg.both_edges;
  assign edge1 = edge_seen(src1, src1_prev_r, 1'b0);
  assign edge2 = edge_seen(src2, src2_prev_r, falling2);
  assign idle1 = clock_idle(src1, 1'b0);
  assign idle2 = clock_idle(src2, falling2);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      src1_prev_r <= 1'b0;
      src2_prev_r <= 1'b0;
    end else begin
      src1_prev_r <= src1;
      src2_prev_r <= src2;
    end
  end

  // gate is only taken while its clock idles, so a pulse is never cut short
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate1_hold_r <= 1'b0;
    end else if (idle1) begin
      gate1_hold_r <= ctl_raw[`CTL_GATE1];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate2_hold_r <= 1'b0;
    end else if (idle2) begin
      gate2_hold_r <= ctl_raw[`CTL_GATE2];
    end
  end

  // aclr and aload are levels, so neither clock gate holds them back; sclr and sload act only on a gated tick
  always_comb begin
    ctl.tick1 = edge1 & gate1_hold_r;
    ctl.tick2 = edge2 & gate2_hold_r;
    ctl.aclr1 = ctl_raw[`CTL_ACLR1];
    ctl.aclr2 = ctl_raw[`CTL_ACLR2];
    ctl.sclr = ctl_raw[`CTL_SCLR];
    ctl.aload = ctl_raw[`CTL_ALOAD];
    ctl.sload = ctl_raw[`CTL_SLOAD];
    ctl.addnsub = ctl_raw[`CTL_ADDSUB];
  end

  // one cycle after reset every cell takes its power-up value
  always_comb begin
    case (st_r)
      cluster_pkg::ST_POWERUP: st_nxt = cluster_pkg::ST_RUN;
      cluster_pkg::ST_RUN: st_nxt = cluster_pkg::ST_RUN;
      default: st_nxt = cluster_pkg::ST_POWERUP;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= cluster_pkg::ST_POWERUP;
    end else begin
      st_r <= st_nxt;
    end
  end

  // power-up load lasts exactly the first edge after reset
  assign init_now = st_r == cluster_pkg::ST_POWERUP;

  // chains run cell to cell without touching local lines
  always_comb begin
    for (int i = 0; i < `NUM_CELLS; i++) begin
      if (i == 0) begin
        lut_chain[i] = 1'b0;
        reg_chain[i] = 1'b0;
        // cell 0 starts the carry chain, so subtract mode feeds it a one
        cin[i] = ctl.addnsub;
      end else begin
        lut_chain[i] = lut_out[i-1];
        reg_chain[i] = q[i-1];
        cin[i] = cout[i-1];
      end
    end
  end

  // ten cells share the same controls and local lines
  for (genvar i = 0; i < `NUM_CELLS; i++) begin : g_cell
    logic [3:0] dsel;
    always_comb begin
      for (int j = 0; j < 4; j++) begin
        dsel[j] = pick({28'h0000000, local_bus}, cell_cfg[i].data_sel[j]);
      end
    end
    logic_cell u_cell (
      .clk(clk),
      .rst(rst),
      .cfg(cell_cfg[i]),
      .ctl(ctl),
      .init(init_now),
      .data(dsel),
      .lut_chain_in(lut_chain[i]),
      .reg_chain_in(reg_chain[i]),
      .carry_in(cin[i]),
      .lut_out(lut_out[i]),
      .carry_out(cout[i]),
      .q(q[i])
    );
  end

  // outputs drive routing and both neighbours; the flop stage isolates fan-out
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cell_out <= 10'h000;
      carry_out <= 1'b0;
    end else begin
      cell_out <= q;
      carry_out <= cout[`NUM_CELLS-1];
    end
  end
endmodule

// *** dv/nbr_cluster.sv ***
// neighbour cluster model driving the side links
`timescale 1ns/1ps
module nbr_cluster (
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] val,
  output logic [9:0] left_r,
  output logic [9:0] right_r
);
  // right link inverted so a swapped pool index shows up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_r <= 10'h000;
      right_r <= 10'h3ff;
    end else begin
      left_r <= val;
      right_r <= ~val;
    end
  end
endmodule

// *** dv/logic_cluster_props.sv ***
// assertions on the logic cluster ports
`timescale 1ns/1ps
module logic_cluster_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] col_clk,
  input wire logic [23:0] route_in,
  input wire logic [9:0] left_in,
  input cluster_pkg::cluster_cfg_t cfg,
  input cluster_pkg::cell_cfg_t [9:0] cell_cfg,
  input wire logic [9:0] cell_out,
  input wire logic carry_out
);
  logic [9:0] pu;
  logic [9:0] ab;
  logic quiet;
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      pu[i] = cell_cfg[i].powerup_high;
      ab[i] = cell_cfg[i].preset_by_aload;
    end
  end
  // only the bench mapping is checked: clock col0, gate col1, clear col2, load col3
  assign quiet = !col_clk[2] && !col_clk[3] && cfg.ctl_sel[0] == 6'h00 && cfg.ctl_sel[2] == 6'h01;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence shift_s;
    $rose(col_clk[0]) && col_clk[1] && $past(col_clk[1]) && quiet;
  endsequence
  sequence mid_s;
    (!col_clk[1]) [*4] ##1 (col_clk[1] && col_clk[0] && quiet);
  endsequence
  AST_RST_ZERO: assert property ($fell(rst) |-> cell_out == 10'h000 && !carry_out)
    else $error("outputs not zero at reset");
  AST_POWERUP: assert property ($fell(rst) |-> ##2 cell_out == pu)
    else $error("powerup value wrong");
  AST_CLEAR: assert property ($rose(col_clk[2]) ##1 col_clk[2] [*5] |-> cell_out == ~ab)
    else $error("clear result wrong");
  AST_ALOAD: assert property ((col_clk[3] && !col_clk[2]) [*6] |-> (cell_out & ab) == ab)
    else $error("load preset wrong");
  AST_GATE_OFF: assert property ((!(|col_clk[3:1])) [*6] |-> $stable(cell_out))
    else $error("output moved with gate low");
  AST_SHIFT: assert property (shift_s |-> ##4 cell_out[9:1] == $past(cell_out[8:0], 4))
    else $error("register chain shift wrong");
  AST_CELL0: assert property (shift_s |-> ##4 cell_out[0] == ($past(route_in[1], 2) ^ $past(left_in[0], 2)))
    else $error("first cell data wrong");
  AST_GATE_MID: assert property (mid_s |-> ##1 $stable(cell_out) [*4])
    else $error("gate change cut a pulse");
endmodule
bind logic_cluster logic_cluster_props props_u (.clk(clk), .rst(rst), .col_clk(col_clk), .route_in(route_in),
  .left_in(left_in), .cfg(cfg), .cell_cfg(cell_cfg), .cell_out(cell_out), .carry_out(carry_out));

// *** dv/logic_cluster_tb.sv ***
// self-checking bench for the logic cluster
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module logic_cluster_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] col_clk = 4'h0;
  logic [23:0] route_in = 24'h000000;
  logic [9:0] val = 10'h000;
  logic [9:0] left_in;
  logic [9:0] right_in;
  logic [9:0] cell_out;
  logic carry_out;
  cluster_pkg::cluster_cfg_t cfg;
  cluster_pkg::cell_cfg_t [9:0] cell_cfg;
  logic [9:0] pu = 10'h2c9;
  logic [9:0] ab = 10'h2aa;
  logic [9:0] exp_q;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  nbr_cluster nbr_u (.clk(clk), .rst(rst), .val(val), .left_r(left_in), .right_r(right_in));
  logic_cluster dut_u (.clk(clk), .rst(rst), .col_clk(col_clk), .route_in(route_in), .left_in(left_in),
    .right_in(right_in), .cfg(cfg), .cell_cfg(cell_cfg), .cell_out(cell_out), .carry_out(carry_out));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic complete_run;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic wait_neg(input int n);
    repeat (n) @(negedge clk);
  endtask
  // pulse is two cycles high, two low so each shift lands before the next rise
  task automatic pulse(input logic d, input logic l, input logic en);
    route_in[1] = d;
    val[0] = l;
    col_clk[0] = 1'b1;
    wait_neg(2);
    col_clk[0] = 1'b0;
    wait_neg(2);
    if (en) exp_q = {exp_q[8:0], d ^ l};
  endtask
  task automatic t_shift;
    col_clk[1] = 1'b1;
    wait_neg(2);
    for (int i = 0; i < 8; i++) pulse(dpat(i), i[0], 1'b1);
    wait_neg(1);
    `CHK("shift", exp_q, cell_out)
  endtask
  function automatic logic dpat(input int i);
    logic [7:0] p;
    p = 8'hb2;
    return p[i];
  endfunction
  task automatic t_gate;
    col_clk[1] = 1'b0;
    wait_neg(2);
    for (int i = 0; i < 3; i++) pulse(1'b1, 1'b0, 1'b0);
    // gate rising together with the clock must not let that pulse through
    col_clk[0] = 1'b1;
    col_clk[1] = 1'b1;
    wait_neg(2);
    col_clk[0] = 1'b0;
    wait_neg(3);
    `CHK("gated", exp_q, cell_out)
    pulse(1'b1, 1'b0, 1'b1);
    wait_neg(1);
    `CHK("regated", exp_q, cell_out)
  endtask
  task automatic t_clear;
    col_clk[2] = 1'b1;
    wait_neg(7);
    `CHK("clear", ~ab, cell_out)
    col_clk[2] = 1'b0;
    col_clk[3] = 1'b1;
    wait_neg(7);
    `CHK("load", ab, cell_out & ab)
    col_clk[3] = 1'b0;
    wait_neg(4);
  endtask
  // every cell sees the same operand bits, so the top carry is that of two ten-bit words
  task automatic t_addsub;
    logic [10:0] sum11;
    for (int i = 0; i < 8; i++) begin
      route_in[1] = i[2];
      val[0] = i[1];
      route_in[2] = i[0];
      wait_neg(4);
      sum11 = {1'b0, {10{i[2]}}} + {1'b0, {10{i[1] ^ i[0]}}} + {10'h000, i[0]};
      `CHK("carry", sum11[10], carry_out)
    end
  endtask
  initial begin
    cfg = '1;
    cfg.clk2_falling = 1'b0;
    cfg.both_edges = 1'b0;
    cfg.line_sel[0] = 6'h01;
    cfg.line_sel[1] = 6'h18;
    cfg.line_sel[2] = 6'h02;
    cfg.ctl_sel[9] = 6'h06;
    cfg.ctl_sel[0] = 6'h00;
    cfg.ctl_sel[2] = 6'h01;
    cfg.ctl_sel[4] = 6'h02;
    cfg.ctl_sel[7] = 6'h03;
    for (int i = 0; i < 10; i++) begin
      cell_cfg[i] = '0;
      cell_cfg[i].lut_mask = 16'h6666;
      cell_cfg[i].data_sel = {6'h3f, 6'h3f, 6'h01, 6'h00};
      cell_cfg[i].use_reg_chain = (i != 0);
      cell_cfg[i].preset_by_aload = ab[i];
      cell_cfg[i].powerup_high = pu[i];
    end
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    wait_neg(4);
    exp_q = pu;
    `CHK("powerup", pu, cell_out)
    t_shift();
    t_gate();
    t_clear();
    t_addsub();
    complete_run();
  end
endmodule
